// ---- verilog/alsu_consts.svh ----
`ifndef ALSU_CONSTS_SVH
`define ALSU_CONSTS_SVH
`define ALSU_ACC_W 32
`define ALSU_WORD_W 16
`define ALSU_ADDR_W 16
`define ALSU_BIT_ADDR_W 16
`define ALSU_STACK_DEPTH 8
`define ALSU_MAX_FIELD 6'd32
`define ALSU_ACC_RESET 32'h0000_0000
`define ALSU_OP_W 4
`endif

// ---- verilog/alsu_pkg.sv ----
package alsu_pkg;
	typedef enum logic [3:0] {
		ALSU_OP_NONE,
		ALSU_OP_LOAD_BIT_FIELD,
		ALSU_OP_LOAD_OCTAL_ADDRESS,
		ALSU_OP_LOAD_INDEXED_WORD,
		ALSU_OP_LOAD_CONSTANT_TABLE_INDEXED,
		ALSU_OP_LOAD_REAL_VALUE,
		ALSU_OP_LOAD_REAL_CONST,
		ALSU_OP_STORE_WORD,
		ALSU_OP_STORE_DOUBLE_WORD
	} alsu_op_t;
endpackage

// ---- verilog/alsu_octal_conv.sv ----
`timescale 1ns/1ps
`include "alsu_consts.svh"
// Octal digits packed four bits apiece; each digit keeps its low three bits.
module alsu_octal_conv (
	input wire logic [23:0] octal_i,
	output logic [15:0] binary_o
);
	logic [17:0] packed_bits;
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_digit
			assign packed_bits[3*g +: 3] = octal_i[4*g +: 3];
		end
	endgenerate
	// Address space is 16 bits; higher octal bits are dropped
	assign binary_o = packed_bits[15:0];
endmodule

// ---- verilog/alsu_unit.sv ----
`timescale 1ns/1ps
`include "alsu_consts.svh"
module alsu_unit import alsu_pkg::*; (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic op_valid_i,
	input wire logic [3:0] op_code_i,
	input wire logic [15:0] op_addr_i,
	input wire logic [31:0] op_const_i,
	input wire logic [5:0] op_count_i,
	input wire logic scan_end_i,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic [31:0] bit_rdata_i,
	input wire logic bit_ack_i,
	output logic op_ready_o,
	output logic op_done_o,
	output logic [31:0] acc_o,
	output logic [31:0] stack_top_o,
	output logic zero_load_flag_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	output logic mem_table_sel_o,
	output logic bit_req_o,
	output logic [15:0] bit_addr_o,
	output logic [5:0] bit_count_o
);
	typedef enum logic [2:0] {
		ALSU_S_IDLE,
		ALSU_S_BITS,
		ALSU_S_RD_LO,
		ALSU_S_RD_HI,
		ALSU_S_WR_LO,
		ALSU_S_WR_HI,
		ALSU_S_DONE
	} alsu_state_t;

	// ==========================================================
	// State
	alsu_state_t state;
	alsu_op_t op;
	logic [31:0] acc;
	logic [31:0] stack [`ALSU_STACK_DEPTH];
	logic prev_load;
	logic zero_flag;
	logic [15:0] addr;
	logic [5:0] count;
	logic [15:0] lo_word;
	logic mem_pend;
	logic bit_pend;

	// ==========================================================
	// Decode
	wire alsu_op_t in_op = alsu_op_t'(op_code_i);
	wire start = op_valid_i && (state == ALSU_S_IDLE) && (in_op != ALSU_OP_NONE);
	wire in_is_load = (in_op != ALSU_OP_STORE_WORD) && (in_op != ALSU_OP_STORE_DOUBLE_WORD);
	wire do_push = start && in_is_load && prev_load;
	wire [15:0] octal_bin;
	// Offset is what stands in stack level one once this load has pushed
	wire [15:0] index_base = do_push ? acc[15:0] : stack[0][15:0];
	wire [15:0] index_addr = op_addr_i + index_base;
	wire [31:0] field_mask = (count >= `ALSU_MAX_FIELD) ? 32'hffff_ffff :
		((32'h0000_0001 << count[4:0]) - 32'h0000_0001);
	wire [31:0] field_val = bit_rdata_i & field_mask;
	wire [5:0] clamp_count = (op_count_i == 6'h00) ? 6'h01 :
		((op_count_i > `ALSU_MAX_FIELD) ? `ALSU_MAX_FIELD : op_count_i);
	wire bits_fin = (state == ALSU_S_BITS) && bit_ack_i;
	wire rd_lo_fin = (state == ALSU_S_RD_LO) && mem_ack_i;
	wire rd_hi_fin = (state == ALSU_S_RD_HI) && mem_ack_i;
	wire single_rd = (op != ALSU_OP_LOAD_REAL_VALUE);
	// Load results, each lands with upper half per its width
	wire [31:0] load_word = {16'h0000, mem_rdata_i};
	wire [31:0] load_real = {mem_rdata_i, lo_word};
	wire [31:0] load_octal = {16'h0000, octal_bin};
	wire imm_load = start && ((in_op == ALSU_OP_LOAD_OCTAL_ADDRESS) ||
		(in_op == ALSU_OP_LOAD_REAL_CONST));
	wire [31:0] imm_val = (in_op == ALSU_OP_LOAD_REAL_CONST) ? op_const_i : load_octal;
	wire load_commit = imm_load || bits_fin || (rd_lo_fin && single_rd) || rd_hi_fin;
	wire [31:0] next_acc = imm_load ? imm_val :
		bits_fin ? field_val :
		rd_hi_fin ? load_real : load_word;

	alsu_octal_conv u_octal (
		.octal_i(op_const_i[23:0]),
		.binary_o(octal_bin)
	);

	// ==========================================================
	// Accumulator and flag
	always_ff @(posedge core_clk_i) begin
		if (rst_i || scan_end_i) begin
			acc <= `ALSU_ACC_RESET;
		end else if (load_commit) begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			zero_flag <= 1'b0;
		end else if (load_commit) begin
			zero_flag <= (next_acc == 32'h0000_0000);
		end
	end

	// Scan end also forgets the prior load, so the next scan starts fresh
	always_ff @(posedge core_clk_i) begin
		if (rst_i || scan_end_i) begin
			prev_load <= 1'b0;
		end else if (start) begin
			prev_load <= in_is_load;
		end
	end

	// ==========================================================
	// Stack
	genvar s;
	generate
		for (s = 0; s < `ALSU_STACK_DEPTH; s++) begin : g_stack
			always_ff @(posedge core_clk_i) begin
				if (rst_i) begin
					stack[s] <= `ALSU_ACC_RESET;
				end else if (do_push) begin
					stack[s] <= (s == 0) ? acc : stack[(s == 0) ? 0 : s - 1];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Sequencer
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= ALSU_S_IDLE;
			op <= ALSU_OP_NONE;
			addr <= 16'h0000;
			count <= 6'h01;
			lo_word <= 16'h0000;
		end else begin
			case (state)
				ALSU_S_IDLE: begin
					if (start) begin
						op <= in_op;
						count <= clamp_count;
						addr <= op_addr_i;
						case (in_op)
							ALSU_OP_LOAD_BIT_FIELD: state <= ALSU_S_BITS;
							ALSU_OP_LOAD_INDEXED_WORD,
							ALSU_OP_LOAD_CONSTANT_TABLE_INDEXED: begin
								addr <= index_addr;
								state <= ALSU_S_RD_LO;
							end
							ALSU_OP_LOAD_REAL_VALUE: state <= ALSU_S_RD_LO;
							ALSU_OP_STORE_WORD,
							ALSU_OP_STORE_DOUBLE_WORD: state <= ALSU_S_WR_LO;
							default: state <= ALSU_S_DONE;
						endcase
					end
				end
				ALSU_S_BITS: if (bit_ack_i) state <= ALSU_S_DONE;
				ALSU_S_RD_LO: begin
					if (mem_ack_i) begin
						lo_word <= mem_rdata_i;
						addr <= addr + 16'h0001;
						state <= single_rd ? ALSU_S_DONE : ALSU_S_RD_HI;
					end
				end
				ALSU_S_RD_HI: if (mem_ack_i) state <= ALSU_S_DONE;
				ALSU_S_WR_LO: begin
					if (mem_ack_i) begin
						addr <= addr + 16'h0001;
						state <= (op == ALSU_OP_STORE_DOUBLE_WORD) ? ALSU_S_WR_HI : ALSU_S_DONE;
					end
				end
				ALSU_S_WR_HI: if (mem_ack_i) state <= ALSU_S_DONE;
				ALSU_S_DONE: state <= ALSU_S_IDLE;
				default: state <= ALSU_S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Registered outputs
	wire in_wr = (state == ALSU_S_WR_LO) || (state == ALSU_S_WR_HI);
	wire in_rd = (state == ALSU_S_RD_LO) || (state == ALSU_S_RD_HI);
	wire [15:0] wr_word = (state == ALSU_S_WR_HI) ? acc[31:16] : acc[15:0];

	// One request pulse per word; a repeat would restart the far side's wait
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			op_ready_o <= 1'b0;
			op_done_o <= 1'b0;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 16'h0000;
			mem_table_sel_o <= 1'b0;
			bit_req_o <= 1'b0;
			bit_addr_o <= 16'h0000;
			bit_count_o <= 6'h01;
			mem_pend <= 1'b0;
			bit_pend <= 1'b0;
		end else begin
			op_ready_o <= (state == ALSU_S_IDLE) && !start;
			op_done_o <= (state == ALSU_S_DONE);
			mem_pend <= (mem_pend || mem_req_o) && !mem_ack_i;
			mem_req_o <= (in_rd || in_wr) && !mem_ack_i && !mem_req_o && !mem_pend;
			mem_we_o <= in_wr;
			mem_addr_o <= addr;
			mem_wdata_o <= wr_word;
			mem_table_sel_o <= (op == ALSU_OP_LOAD_CONSTANT_TABLE_INDEXED);
			bit_pend <= (bit_pend || bit_req_o) && !bit_ack_i;
			bit_req_o <= (state == ALSU_S_BITS) && !bit_ack_i && !bit_req_o && !bit_pend;
			bit_addr_o <= addr;
			bit_count_o <= count;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			acc_o <= `ALSU_ACC_RESET;
			stack_top_o <= `ALSU_ACC_RESET;
			zero_load_flag_o <= 1'b0;
		end else begin
			acc_o <= acc;
			stack_top_o <= stack[0];
			zero_load_flag_o <= zero_flag;
		end
	end

	// ==========================================================
	// Checks
	sequence load_seen;
		load_commit;
	endsequence

	zero_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		load_seen |=> (zero_flag == (acc == 32'h0000_0000) || scan_end_i == 1'b1 ||
			$past(scan_end_i)))
		else $error("zero flag disagrees with loaded value");

	push_shift_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		do_push |=> (stack[0] == $past(acc)) && (stack[7] == $past(stack[6])))
		else $error("stack push did not shift");

	push_cond_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(start && !in_is_load) |=> $stable(stack[0]))
		else $error("store pushed stack");

	scan_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		scan_end_i |=> acc == 32'h0000_0000)
		else $error("accumulator not cleared at scan end");

	field_upper_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(bits_fin && !scan_end_i && count < 6'd32) |=> (acc >> count) == 32'h0000_0000)
		else $error("bits above field not cleared");

	index_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rd_lo_fin && single_rd && !scan_end_i) |=> acc[31:16] == 16'h0000)
		else $error("indexed load left upper half");

	double_store_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state == ALSU_S_WR_HI) |=> mem_wdata_o == $past(acc[31:16]))
		else $error("double store high word wrong");

	single_wait_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state == ALSU_S_RD_LO && !mem_ack_i) |=> state == ALSU_S_RD_LO)
		else $error("read left before completion");

	octal_conv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(start && in_op == ALSU_OP_LOAD_OCTAL_ADDRESS && !scan_end_i) |=>
			acc == {16'h0000, $past(octal_bin)})
		else $error("octal load wrong");

	mem_single_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(mem_pend && !mem_ack_i) |-> !mem_req_o)
		else $error("second memory request while one is open");

	bit_single_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(bit_pend && !bit_ack_i) |-> !bit_req_o)
		else $error("second bit request while one is open");

	index_base_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(start && (in_op == ALSU_OP_LOAD_INDEXED_WORD ||
			in_op == ALSU_OP_LOAD_CONSTANT_TABLE_INDEXED)) |=>
			addr == $past(op_addr_i) + stack[0][15:0])
		else $error("indexed address not offset by stack level one");

	store_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(state == ALSU_S_WR_LO) |=> mem_wdata_o == $past(acc[15:0]))
		else $error("store low word wrong");

	real_pair_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(rd_hi_fin && !scan_end_i) |=> acc == {$past(mem_rdata_i), $past(lo_word)})
		else $error("real load word pair wrong");
endmodule

// ---- dv/alsu_mem_model.sv ----
`timescale 1ns/1ps
// ==========
// Word and discrete bit memory
module alsu_mem_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	input wire logic mem_table_sel_i,
	input wire logic bit_req_i,
	input wire logic [15:0] bit_addr_i,
	output logic [15:0] mem_rdata_o,
	output logic mem_ack_o,
	output logic [31:0] bit_rdata_o,
	output logic bit_ack_o
);
	logic [15:0] mem [0:255];
	logic [15:0] tbl [0:255];
	logic [1:0] mwait;
	logic [1:0] bwait;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'h1000 + 16'(i);
			tbl[i] = 16'h2000 + 16'(i);
		end
		mem_rdata_o = 16'h0000;
		bit_rdata_o = 32'h0000_0000;
	end
	// ==========
	// Answers after one or three cycles; data lines scramble when idle
	always @(posedge core_clk_i) begin
		mem_ack_o <= 1'b0;
		bit_ack_o <= 1'b0;
		if (rst_i) begin
			mwait <= 2'd0;
			bwait <= 2'd0;
		end else begin
			if (mem_req_i) mwait <= slow_i ? 2'd3 : 2'd1;
			else if (mwait != 2'd0) mwait <= mwait - 2'd1;
			if (bit_req_i) bwait <= slow_i ? 2'd3 : 2'd1;
			else if (bwait != 2'd0) bwait <= bwait - 2'd1;
		end
		if (!rst_i && mwait == 2'd1) begin
			mem_ack_o <= 1'b1;
			if (mem_we_i) mem[mem_addr_i[7:0]] <= mem_wdata_i;
			mem_rdata_o <= mem_table_sel_i ? tbl[mem_addr_i[7:0]] : mem[mem_addr_i[7:0]];
		end else mem_rdata_o <= ~mem_rdata_o;
		if (!rst_i && bwait == 2'd1) begin
			bit_ack_o <= 1'b1;
			bit_rdata_o <= {~bit_addr_i, bit_addr_i};
		end else bit_rdata_o <= ~bit_rdata_o;
	end
endmodule

// ---- dv/accumulator_load_store_unit_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module accumulator_load_store_unit_tb import alsu_pkg::*;;
	logic core_clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, scan_end_i = 1'b0, slow = 1'b0;
	logic [3:0] op_code_i = 4'h0;
	logic [15:0] op_addr_i = 16'h0000, mem_rdata_i, mem_addr_o, mem_wdata_o, bit_addr_o;
	logic [31:0] op_const_i = 32'h0, bit_rdata_i, acc_o, stack_top_o, e_acc, e_top;
	logic [5:0] op_count_i = 6'h01, bit_count_o;
	logic mem_ack_i, bit_ack_i, op_ready_o, op_done_o, zero_load_flag_o, mem_req_o, mem_we_o;
	logic mem_table_sel_o, bit_req_o, was_load;
	int miscompares = 0, num_checks = 0;
	alsu_unit dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
		.op_code_i(op_code_i), .op_addr_i(op_addr_i), .op_const_i(op_const_i),
		.op_count_i(op_count_i), .scan_end_i(scan_end_i), .mem_rdata_i(mem_rdata_i),
		.mem_ack_i(mem_ack_i), .bit_rdata_i(bit_rdata_i), .bit_ack_i(bit_ack_i),
		.op_ready_o(op_ready_o), .op_done_o(op_done_o), .acc_o(acc_o),
		.stack_top_o(stack_top_o), .zero_load_flag_o(zero_load_flag_o), .mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_table_sel_o(mem_table_sel_o), .bit_req_o(bit_req_o), .bit_addr_o(bit_addr_o),
		.bit_count_o(bit_count_o));
	alsu_mem_model u_mem (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
		.mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .mem_table_sel_i(mem_table_sel_o), .bit_req_i(bit_req_o),
		.bit_addr_i(bit_addr_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
		.bit_rdata_o(bit_rdata_i), .bit_ack_o(bit_ack_i));
	initial begin
		forever #4 core_clk_i = ~core_clk_i;
	end
	task automatic complete_run();
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// Bounded wait for a flag, sampled after the edge settles
	task automatic wait_flag(input int which);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge core_clk_i);
			#1;
			if ((which == 0 ? op_ready_o : op_done_o) === 1'b1) break;
		end
		if (i == 60) begin
			miscompares++;
			complete_run();
		end
	endtask
	// ==========
	// One operation; tracks the expected accumulator and stack top
	task automatic do_op(input logic [3:0] op, input logic [15:0] a, input logic [31:0] k,
		input logic [5:0] n, input logic [31:0] e);
		logic ld;
		ld = (op >= 4'h1 && op <= 4'h6);
		wait_flag(0);
		@(posedge core_clk_i);
		op_valid_i <= 1'b1;
		op_code_i <= op;
		op_addr_i <= a;
		op_const_i <= k;
		op_count_i <= n;
		@(posedge core_clk_i);
		op_valid_i <= 1'b0;
		wait_flag(1);
		wait_flag(0);
		if (ld && was_load) e_top = e_acc;
		if (ld) e_acc = e;
		was_load = ld;
		`CHK("acc", e_acc, acc_o)
		`CHK("stack_top", e_top, stack_top_o)
		if (ld) `CHK("zero_flag", (e == 32'h0), zero_load_flag_o)
	endtask
	task automatic t_bit_field();
		logic [15:0] ad [6] = '{16'h0003, 16'h0010, 16'h1234, 16'h0001, 16'hfffe, 16'h0010};
		logic [5:0] cn [6] = '{6'd1, 6'd7, 6'd32, 6'd0, 6'd40, 6'd4};
		int c;
		for (int i = 0; i < 6; i++) begin
			c = cn[i] == 6'd0 ? 1 : (cn[i] > 6'd32 ? 32 : int'(cn[i]));
			do_op(ALSU_OP_LOAD_BIT_FIELD, ad[i], 32'h0, cn[i], {~ad[i], ad[i]} &
				(c == 32 ? 32'hffff_ffff : (32'h1 << c) - 32'h1));
			`CHK("bit_count", 6'(c), bit_count_o)
		end
	endtask
	task automatic t_octal();
		do_op(ALSU_OP_LOAD_OCTAL_ADDRESS, 16'h0, 32'h0004_0400, 6'd1, 32'h4100);
		do_op(ALSU_OP_LOAD_OCTAL_ADDRESS, 16'h0, 32'h0000_0000, 6'd1, 32'h0);
	endtask
	task automatic t_indexed();
		do_op(ALSU_OP_LOAD_REAL_CONST, 16'h0, 32'hffff_ffff, 6'd1, 32'hffff_ffff);
		do_op(ALSU_OP_LOAD_OCTAL_ADDRESS, 16'h0, 32'h0000_0025, 6'd1, 32'h15);
		do_op(ALSU_OP_LOAD_INDEXED_WORD, 16'h0008, 32'h0, 6'd1, 32'h101d);
	endtask
	task automatic t_ctable();
		do_op(ALSU_OP_LOAD_OCTAL_ADDRESS, 16'h0, 32'h0000_0001, 6'd1, 32'h1);
		do_op(ALSU_OP_LOAD_CONSTANT_TABLE_INDEXED, 16'h0002, 32'h0, 6'd1, 32'h2003);
	endtask
	task automatic t_real_store();
		slow = 1'b1;
		do_op(ALSU_OP_LOAD_REAL_VALUE, 16'h0004, 32'h0, 6'd1, 32'h1005_1004);
		do_op(ALSU_OP_STORE_WORD, 16'h0040, 32'h0, 6'd1, 32'h0);
		`CHK("word_store", 16'h1004, u_mem.mem[8'h40])
		do_op(ALSU_OP_STORE_DOUBLE_WORD, 16'h0050, 32'h0, 6'd1, 32'h0);
		`CHK("dbl_low", 16'h1004, u_mem.mem[8'h50])
		`CHK("dbl_high", 16'h1005, u_mem.mem[8'h51])
		slow = 1'b0;
		do_op(ALSU_OP_LOAD_OCTAL_ADDRESS, 16'h0, 32'h0000_0007, 6'd1, 32'h7);
	endtask
	task automatic t_scan();
		@(posedge core_clk_i);
		scan_end_i <= 1'b1;
		@(posedge core_clk_i);
		scan_end_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
		`CHK("acc_scan", 32'h0, acc_o)
		e_acc = 32'h0;
		was_load = 1'b0;
		do_op(ALSU_OP_LOAD_OCTAL_ADDRESS, 16'h0, 32'h0000_0003, 6'd1, 32'h3);
	endtask
	initial begin
		e_acc = 32'h0;
		e_top = 32'h0;
		was_load = 1'b0;
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_bit_field();
		t_octal();
		t_indexed();
		t_ctable();
		t_real_store();
		t_scan();
		complete_run();
	end
endmodule
